// *** logic/laser_supervisor_params.svh ***
// Constants for the laser driver and cooler supervisor: register offsets,
// field positions, reset values and timing counts.
// Assumes a 200 MHz system clock and a 32-bit AXI4-Lite register bus.
`ifndef LASER_SUPERVISOR_PARAMS_SVH
`define LASER_SUPERVISOR_PARAMS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_CONTROL        8'h00
`define OFS_STATUS         8'h04
`define OFS_THERM_TEMP     8'h08
`define OFS_LIMIT_HIGH     8'h0C
`define OFS_LIMIT_LOW      8'h10

// ****************************************************************
// Control register fields
// ****************************************************************
`define CTL_COOLER_SRC_BIT   0
`define CTL_CURRENT_SRC_BIT  1
`define CTL_IGNORE_LOCK_BIT  2
`define CTL_LIMITS_SET_BIT   3
`define CTL_RESET_VALUE      32'h0000_0000

// ****************************************************************
// Status register fields
// ****************************************************************
`define STS_COOLER_RUN_BIT   0
`define STS_LASER_RUN_BIT    1
`define STS_COOLER_FAULT_BIT 2
`define STS_OVERCURRENT_BIT  3
`define STS_LOCKED_BIT       4
`define STS_THERM_BLOCK_BIT  5
`define STS_SOFT_START_BIT   6

// ****************************************************************
// Limit reset values and timing
// ****************************************************************
`define LIMIT_HIGH_RESET   16'h7FFF
`define LIMIT_LOW_RESET    16'h8000
`define SOFT_START_NS      1000
`define CLK_PERIOD_NS      5
`define SOFT_START_CYCLES  ((`SOFT_START_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** logic/laser_supervisor_pkg.sv ***
// Types shared by the laser driver and cooler supervisor.
// Assumes the parameter header is compiled alongside.
package laser_supervisor_pkg;

    typedef enum logic [1:0] {
        LASER_OFF,
        LASER_SOFT_START,
        LASER_ON,
        LASER_TRIPPED
    } laser_state_e;

    typedef enum logic [1:0] {
        SRC_POTENTIOMETER,
        SRC_CONNECTOR,
        SRC_DIGITAL
    } setpoint_src_e;

endpackage

// *** logic/sync_bits.sv ***
// Two-stage synchroniser for a group of single-bit levels.
// Assumes every input is a level that may change at any time.
`timescale 1ns/1ps
module sync_bits #(
    parameter int WIDTH = 1
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] reset_value,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_q;

    initial begin
        if (WIDTH < 1) begin
            $error("sync_bits width must be at least one");
        end
    end

    // The first stage is read only by the second stage.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1_q <= reset_value;
            sync_out <= reset_value;
        end else begin
            stage1_q <= async_in;
            sync_out <= stage1_q;
        end
    end
endmodule // sync_bits

// *** logic/laser_supervisor.sv ***
// Supervisor for a laser diode driver with a thermoelectric cooler stage.
// Assumes asynchronous level pins from the board and an AXI4-Lite master.
//
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "laser_supervisor_params.svh"
module laser_supervisor
    import laser_supervisor_pkg::*;
#(
    parameter int SOFT_START_CYCLES = `SOFT_START_CYCLES,
    parameter int TEMP_WIDTH        = 16
) (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // Board pins, pulled to their inactive levels outside.
    input  wire logic                  cooler_run_request,
    input  wire logic                  laser_run_request,
    input  wire logic                  cooler_switch_on,
    input  wire logic                  laser_switch_on,
    input  wire logic                  interlock_open,
    input  wire logic                  cooler_overcurrent,
    input  wire logic                  cooler_short,
    input  wire logic                  cooler_overheat,
    input  wire logic                  laser_overcurrent,
    input  wire logic                  connector_source_jumper_cooler,
    input  wire logic                  connector_source_jumper_current,
    input  wire logic [TEMP_WIDTH-1:0] thermistor_temp,
    // Outputs to the stages and the connectors.
    output logic                       cooler_enable,
    output logic                       laser_enable,
    output logic                       laser_soft_start,
    output logic                       output_shunt,
    output logic                       red_indicator,
    output logic                       yellow_indicator,
    output logic                       cooler_fault_flag,
    output logic                       overcurrent_flag,
    output logic                       shunt_status,
    output logic                       interlock_copy,
    output logic [1:0]                 cooler_source,
    output logic [1:0]                 current_source,
    // AXI4-Lite slave.
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [7:0]            s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready
);

    // ****************************************************************
    // Elaboration checks and helpers
    // ****************************************************************
    initial begin
        if (SOFT_START_CYCLES < 1 || TEMP_WIDTH < 2 || TEMP_WIDTH > 32) begin
            $error("laser_supervisor parameters out of range");
        end
    end

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Merges a 32-bit write into a register under byte strobes.
    function automatic logic [31:0] apply_strobe(input logic [31:0] old_v,
                                                 input logic [31:0] new_v,
                                                 input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Chooses a set-point source from the digital state and the jumper.
    function automatic logic [1:0] pick_source(input logic internal_state,
                                               input logic jumper_on_connector);
        setpoint_src_e s;
        if (internal_state) begin
            s = SRC_DIGITAL;
        end else if (jumper_on_connector) begin
            s = SRC_CONNECTOR;
        end else begin
            s = SRC_POTENTIOMETER;
        end
        return s;
    endfunction

    // ****************************************************************
    // Input synchronisation
    // ****************************************************************
    localparam int NSYNC = 11;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] sync_in;
    logic [TEMP_WIDTH-1:0] temp_s1_q;
    logic [TEMP_WIDTH-1:0] temp_q;

    assign raw_in = {connector_source_jumper_current, connector_source_jumper_cooler,
                     laser_overcurrent, cooler_overheat, cooler_short,
                     cooler_overcurrent, interlock_open, laser_switch_on,
                     cooler_switch_on, laser_run_request, cooler_run_request};

    sync_bits #(
        .WIDTH (NSYNC)
    ) u_sync (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .reset_value (11'h010),
        .async_in    (raw_in),
        .sync_out    (sync_in)
    );

    // Temperature word is assumed stable between conversions of the sensor front end.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            temp_s1_q <= '0;
            temp_q    <= '0;
        end else begin
            temp_s1_q <= thermistor_temp;
            temp_q    <= temp_s1_q;
        end
    end

    logic cooler_req;
    logic laser_req;
    logic locked;
    logic cooler_fault_now;
    logic overcurrent_now;

    // Requests are level-sensed, so a request held through power-up starts the stage.
    assign cooler_req = sync_in[0] | sync_in[2];
    assign laser_req  = sync_in[1] | sync_in[3];
    assign cooler_fault_now = sync_in[5] | sync_in[6] | sync_in[7];
    assign overcurrent_now  = sync_in[8];

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [31:0]           control_q;
    logic [TEMP_WIDTH-1:0] limit_high_q;
    logic [TEMP_WIDTH-1:0] limit_low_q;
    logic                  cooler_fault_q;
    logic                  trip_q;
    logic                  therm_block_q;
    logic                  laser_req_prev_q;
    laser_state_e          laser_state_q;
    logic [31:0]           ss_count_q;

    // Interlock honoured unless software sets the ignore bit.
    assign locked = sync_in[4] & ~control_q[`CTL_IGNORE_LOCK_BIT];

    // ****************************************************************
    // AXI4-Lite write path
    // ****************************************************************
    logic       aw_held_q;
    logic       w_held_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic       do_write;

    assign do_write = aw_held_q & w_held_q & ~s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            aw_addr_q     <= 8'h00;
            w_data_q      <= 32'h0000_0000;
            w_strb_q      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_held_q & ~s_axi_awready & ~(s_axi_awvalid & s_axi_awready);
            s_axi_wready  <= ~w_held_q & ~s_axi_wready & ~(s_axi_wvalid & s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q     <= 1'b1;
                aw_addr_q     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q     <= 1'b1;
                w_data_q     <= s_axi_wdata;
                w_strb_q     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (aw_addr_q)
                    `OFS_CONTROL, `OFS_LIMIT_HIGH, `OFS_LIMIT_LOW: begin
                        s_axi_bresp <= RESP_OKAY;
                    end
                    `OFS_STATUS, `OFS_THERM_TEMP: begin
                        s_axi_bresp <= RESP_OKAY;
                    end
                    default: begin
                        s_axi_bresp <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Limits are held once written and apply whatever the source mode.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            control_q    <= `CTL_RESET_VALUE;
            limit_high_q <= TEMP_WIDTH'(`LIMIT_HIGH_RESET);
            limit_low_q  <= TEMP_WIDTH'(`LIMIT_LOW_RESET);
        end else if (do_write) begin
            case (aw_addr_q)
                `OFS_CONTROL: begin
                    control_q <= apply_strobe(control_q, w_data_q, w_strb_q) & 32'h0000_000F;
                end
                `OFS_LIMIT_HIGH: begin
                    limit_high_q <= TEMP_WIDTH'(apply_strobe(32'(limit_high_q), w_data_q,
                                                             w_strb_q));
                end
                `OFS_LIMIT_LOW: begin
                    limit_low_q <= TEMP_WIDTH'(apply_strobe(32'(limit_low_q), w_data_q,
                                                            w_strb_q));
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************************************
    // AXI4-Lite read path
    // ****************************************************************
    logic [31:0] status_word;
    assign status_word = {25'h000_0000,
                          laser_state_q == LASER_SOFT_START,
                          therm_block_q, locked, trip_q, cooler_fault_q,
                          laser_enable, cooler_enable};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= RESP_OKAY;
                case (s_axi_araddr)
                    `OFS_CONTROL:    s_axi_rdata <= control_q;
                    `OFS_STATUS:     s_axi_rdata <= status_word;
                    `OFS_THERM_TEMP: s_axi_rdata <= 32'(temp_q);
                    `OFS_LIMIT_HIGH: s_axi_rdata <= 32'(limit_high_q);
                    `OFS_LIMIT_LOW:  s_axi_rdata <= 32'(limit_low_q);
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Protection latch and thermal window
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cooler_fault_q <= 1'b0;
        end else if (cooler_fault_now) begin
            cooler_fault_q <= 1'b1;
        end
    end

    // Signed window compare; an enabled window blocks outside the limits.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            therm_block_q <= 1'b0;
        end else begin
            therm_block_q <= control_q[`CTL_LIMITS_SET_BIT] &
                             (($signed(temp_q) > $signed(limit_high_q)) |
                              ($signed(temp_q) < $signed(limit_low_q)));
        end
    end

    // ****************************************************************
    // Laser driver sequencing
    // ****************************************************************
    logic laser_permit;
    assign laser_permit = ~locked & ~cooler_fault_q & ~therm_block_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            laser_state_q    <= LASER_OFF;
            ss_count_q       <= 32'h0000_0000;
            trip_q           <= 1'b0;
            laser_req_prev_q <= 1'b0;
        end else begin
            laser_req_prev_q <= laser_req;
            case (laser_state_q)
                LASER_OFF: begin
                    ss_count_q <= 32'h0000_0000;
                    if (laser_req && laser_permit) begin
                        laser_state_q <= LASER_SOFT_START;
                    end
                end
                LASER_SOFT_START, LASER_ON: begin
                    if (overcurrent_now) begin
                        laser_state_q <= LASER_TRIPPED;
                        trip_q        <= 1'b1;
                    end else if (!laser_req || !laser_permit) begin
                        laser_state_q <= LASER_OFF;
                    end else if (laser_state_q == LASER_SOFT_START) begin
                        ss_count_q <= ss_count_q + 32'd1;
                        if (ss_count_q >= 32'(SOFT_START_CYCLES - 1)) begin
                            laser_state_q <= LASER_ON;
                        end
                    end
                end
                LASER_TRIPPED: begin
                    // Only a stop then a fresh request restarts the driver.
                    if (!laser_req) begin
                        laser_state_q <= LASER_OFF;
                        trip_q        <= 1'b0;
                    end
                end
                default: begin
                    laser_state_q <= LASER_OFF;
                end
            endcase
        end
    end

    // ****************************************************************
    // Registered outputs
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cooler_enable     <= 1'b0;
            laser_enable      <= 1'b0;
            laser_soft_start  <= 1'b0;
            output_shunt      <= 1'b0;
            red_indicator     <= 1'b0;
            yellow_indicator  <= 1'b0;
            cooler_fault_flag <= 1'b0;
            overcurrent_flag  <= 1'b0;
            shunt_status      <= 1'b0;
            interlock_copy    <= 1'b0;
            cooler_source     <= SRC_POTENTIOMETER;
            current_source    <= SRC_POTENTIOMETER;
        end else begin
            cooler_enable     <= cooler_req & ~locked & ~therm_block_q;
            laser_enable      <= (laser_state_q == LASER_SOFT_START) |
                                 (laser_state_q == LASER_ON);
            laser_soft_start  <= laser_state_q == LASER_SOFT_START;
            output_shunt      <= trip_q;
            red_indicator     <= trip_q;
            yellow_indicator  <= sync_in[4];
            cooler_fault_flag <= cooler_fault_q;
            overcurrent_flag  <= trip_q;
            shunt_status      <= trip_q;
            interlock_copy    <= sync_in[4];
            cooler_source     <= pick_source(control_q[`CTL_COOLER_SRC_BIT],
                                             sync_in[9]);
            current_source    <= pick_source(control_q[`CTL_CURRENT_SRC_BIT],
                                             sync_in[10]);
        end
    end

endmodule // laser_supervisor

// *** sim/laser_supervisor_props.sv ***
// Checker for the laser supervisor pin behaviour.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module laser_supervisor_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic cooler_run_request,
    input wire logic laser_run_request,
    input wire logic cooler_switch_on,
    input wire logic laser_switch_on,
    input wire logic cooler_short,
    input wire logic cooler_enable,
    input wire logic laser_enable,
    input wire logic laser_soft_start,
    input wire logic output_shunt,
    input wire logic red_indicator,
    input wire logic shunt_status,
    input wire logic cooler_fault_flag,
    input wire logic overcurrent_flag
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_shunt_mirror: assert property (shunt_status == overcurrent_flag)
        else $error("shunt status differs from overcurrent output");
    chk_trip_shunts: assert property (overcurrent_flag |->
        output_shunt && red_indicator && !laser_enable)
        else $error("trip without shunt, indicator or laser stop");
    chk_trip_held: assert property ((laser_run_request || laser_switch_on)[*4]
        ##0 overcurrent_flag |=> overcurrent_flag)
        else $error("trip cleared while laser still requested");
    chk_fault_sticky: assert property (cooler_fault_flag |=> cooler_fault_flag)
        else $error("cooler fault cleared without reset");
    chk_fault_stops: assert property (cooler_fault_flag |-> ##[0:4] !laser_enable)
        else $error("laser still on after cooler fault");
    chk_fault_raise: assert property (cooler_short |-> ##[1:5] cooler_fault_flag)
        else $error("cooler short not flagged");
    chk_laser_stop: assert property ((!laser_run_request && !laser_switch_on)[*6]
        |-> !laser_enable && !laser_soft_start)
        else $error("laser runs without request");
    chk_cooler_stop: assert property ((!cooler_run_request && !cooler_switch_on)[*6]
        |-> !cooler_enable)
        else $error("cooler runs without request");
    chk_soft_start: assert property ($rose(laser_soft_start) |-> laser_soft_start[*3])
        else $error("soft start cut short");

    cover property ($rose(overcurrent_flag));
    cover property ($rose(cooler_fault_flag));
    cover property ($rose(laser_enable));
endmodule // laser_supervisor_props

bind laser_supervisor laser_supervisor_props chk (.*);

// *** sim/host_pins.sv ***
// Host equipment model driving the run request and interlock pins.
// Assumes a detached harness leaves the pins to the board pulls.
`timescale 1ns/1ps
module host_pins (
    input  wire logic       aclk,
    input  wire logic       attached,
    input  wire logic [1:0] run_cmd,
    input  wire logic       lock_cmd,
    output logic            cooler_run_request = 1'b0,
    output logic            laser_run_request = 1'b0,
    output logic            interlock_open = 1'b1
);
    always_ff @(posedge aclk) begin
        cooler_run_request <= attached & run_cmd[0];
        laser_run_request  <= attached & run_cmd[1];
        interlock_open     <= !(attached & lock_cmd);
    end
endmodule // host_pins

// *** sim/laser_supervisor_test.sv ***
// Bench for the laser supervisor: sources, interlock, trips, faults, registers.
// Assumes the design, the checker and the host model are compiled first.
`timescale 1ns/1ps
`include "laser_supervisor_params.svh"
module laser_supervisor_test import laser_supervisor_pkg::*;;
    typedef struct packed {logic [1:0] ctl; logic jc; logic ji; logic [1:0] ec, ei;} row_s;
    row_s rows [5] = '{'{2'h0, 1'b0, 1'b1, SRC_POTENTIOMETER, SRC_CONNECTOR},
        '{2'h0, 1'b1, 1'b0, SRC_CONNECTOR, SRC_POTENTIOMETER},
        '{2'h1, 1'b1, 1'b1, SRC_DIGITAL, SRC_CONNECTOR},
        '{2'h2, 1'b1, 1'b0, SRC_CONNECTOR, SRC_DIGITAL},
        '{2'h3, 1'b0, 1'b1, SRC_DIGITAL, SRC_DIGITAL}};
    logic aclk = '0, aresetn = '0, attached = '0, lock_cmd = '0, cooler_switch_on = '0;
    logic laser_switch_on = '0, cooler_overcurrent = '0, cooler_short = '0;
    logic cooler_overheat = '0, laser_overcurrent = '0, connector_source_jumper_cooler = '0;
    logic connector_source_jumper_current = '0, s_axi_awvalid = '0, s_axi_wvalid = '0;
    logic s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
    logic [1:0] run_cmd = '0, cooler_source, current_source, s_axi_bresp, s_axi_rresp, r;
    logic [15:0] thermistor_temp = 16'h8123;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic cooler_run_request, laser_run_request, interlock_open, cooler_enable, laser_enable;
    logic laser_soft_start, output_shunt, red_indicator, yellow_indicator, cooler_fault_flag;
    logic overcurrent_flag, shunt_status, interlock_copy, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    int n_fail = 0, num_checks = 0, cycles = 0;

    laser_supervisor #(.SOFT_START_CYCLES(4)) dut (.*);
    host_pins host (.*);

    initial forever #2.5 aclk = ~aclk;
    always @(posedge aclk) if (++cycles == 5000) begin n_fail++; close_out(); end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n); repeat (n) @(posedge aclk); endtask
    task automatic rst(input int n); aresetn <= 1'b0; cyc(n); aresetn <= 1'b1; endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        {d, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
    endtask
    task automatic close_out();
        $display("checks=%0d failures=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        rst(20);
        cyc(4);
        check({cooler_enable, laser_enable, cooler_fault_flag, cooler_source}, 5'h0);
        rd(`OFS_CONTROL);
        check(d, `CTL_RESET_VALUE);
        foreach (rows[i]) begin
            wr(`OFS_CONTROL, {30'h0, rows[i].ctl});
            connector_source_jumper_cooler <= rows[i].jc;
            connector_source_jumper_current <= rows[i].ji;
            cyc(6);
            check({cooler_source, current_source}, {rows[i].ec, rows[i].ei});
        end
        {attached, run_cmd} <= 3'h5;
        wr(`OFS_CONTROL, 32'h0000_0000);
        cyc(8);
        check({cooler_enable, yellow_indicator, interlock_copy}, 3'h3);
        wr(`OFS_CONTROL, 32'h0000_0004);
        cyc(8);
        check(cooler_enable, 1'b1);
        wr(`OFS_CONTROL, 32'h0000_0000);
        lock_cmd <= 1'b1;
        cyc(8);
        check(cooler_enable, 1'b1);
        {run_cmd, cooler_switch_on, laser_switch_on} <= 4'h3;
        cyc(15);
        check({cooler_enable, laser_enable}, 2'h3);
        laser_overcurrent <= 1'b1;
        cyc(6);
        laser_overcurrent <= 1'b0;
        cyc(10);
        check({laser_enable, output_shunt, red_indicator, shunt_status}, 4'h7);
        rd(`OFS_STATUS);
        check(d[`STS_OVERCURRENT_BIT], 1'b1);
        laser_switch_on <= 1'b0;
        cyc(8);
        check(overcurrent_flag, 1'b0);
        run_cmd <= 2'h2;
        cyc(15);
        check(laser_enable, 1'b1);
        rd(`OFS_THERM_TEMP);
        check(d, 32'h0000_8123);
        wr(`OFS_LIMIT_HIGH, 32'h0000_0010);
        rd(`OFS_LIMIT_HIGH);
        check(d[15:0], 16'h0010);
        check(laser_enable, 1'b1);
        wr(`OFS_LIMIT_LOW, 32'h0000_0000);
        cyc(1);
        wr(`OFS_CONTROL, 32'h0000_0008);
        cyc(8);
        rd(`OFS_STATUS);
        check({laser_enable, cooler_enable, d[`STS_THERM_BLOCK_BIT]}, 3'h1);
        wr(`OFS_LIMIT_LOW, 32'h0000_8000);
        cyc(4);
        check({laser_soft_start, laser_enable}, 2'h3);
        cyc(4);
        check({laser_enable, laser_soft_start, cooler_enable}, 3'h5);
        rd(8'h40);
        check({d[3:0], r}, 6'h2);
        wr(8'h40, 32'h0000_0007);
        check(r, 2'h2);
        for (int k = 0; k < 3; k++) begin
            {cooler_overcurrent, cooler_short, cooler_overheat} <= 3'h1 << k;
            cyc(6);
            {cooler_overcurrent, cooler_short, cooler_overheat} <= 3'h0;
            cyc(8);
            check({cooler_fault_flag, laser_enable}, 2'h2);
            rst(3);
            cyc(8);
            check({cooler_fault_flag, cooler_enable}, 2'h1);
        end
        close_out();
    end
endmodule // laser_supervisor_test
